// ===== design/bier_consts.vh
`ifndef BIER_CONSTS_VH
`define BIER_CONSTS_VH
`define BIER_OFS_BIAS 4'h4
`define BIER_OFS_IDENT 4'h5
`define BIER_OFS_FAULT 4'h6
`define BIER_OFS_FAULT_EN 4'h7
`define BIER_OFS_IRQ_STAT 4'h8
`define BIER_OFS_IRQ_MASK 4'h9
`define BIER_RST_BIAS 16'h0000
`define BIER_RST_FAULT 16'h0000
`define BIER_RST_FAULT_EN 16'h0000
`define BIER_FAULT_LIVE 16'h0FFF
`define BIER_IDENT_RSVD_HI 7
`define BIER_IDENT_RSVD_LO 4
`define BIER_IDENT_REV_HI 3
`define BIER_IDENT_REV_LO 2
`define BIER_IDENT_VAR_HI 1
`define BIER_IDENT_VAR_LO 0
`define BIER_IRQ_FAULT_BIT 0
`define BIER_IRQ_BITS 2'h3
`endif

// ===== design/bier_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser, one per bit, for the raw fault event inputs.
module bier_sync #(
   parameter WIDTH = 12
) (
   input wire ref_clk,
   input wire rst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] stable_reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge ref_clk) begin
            if (rst) begin
               meta_reg[i] <= 1'b0;
               stable_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               stable_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign sync_out = stable_reg;
endmodule // bier_sync

// ===== design/bier_regs.v
// Operation
// - Bias enable register at offset 0x04, all zeros after reset.
// - Bias bit n controls pin n only; every bit read/write.
// - Bit at one drives bias onto its pin; zero disables it.
// - Identification register at 0x05; value set by fitted model.
// - Identification is 8-bit read-only: reserved top, revision, then variant.
// - Variant field fixed per product, encodes resolution and package; writes ignored.
// - Fault register at 0x06, reset zero, top four bits reserved.
// - Fault flags readable, cleared by writing one; zero leaves unchanged.
// - A fault flag sets only when its enable bit is set.
`timescale 1ns/1ns
`include "bier_consts.vh"
module bier_regs #(
   parameter PINS = 16,
   parameter FAULTS = 12,
   parameter [1:0] DIE_REVISION = 2'h2,
   parameter [1:0] VARIANT = 2'h3
) (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire [FAULTS-1:0] fault_event_in,
   output reg [PINS-1:0] input_bias_voltage_en,
   output reg irq
);
   // DIE_REVISION and VARIANT defaults are arbitrary; they stand in for the fitted model.

   ////////////////////////////////////////////////////////////////////////
   reg [PINS-1:0] pin_bias_enable_map_reg;
   reg [15:0] fault_flags_reg;
   reg [15:0] fault_enable_reg;
   reg [1:0] irq_stat_reg;
   reg [1:0] irq_mask_reg;
   reg [FAULTS-1:0] fault_seen_reg;
   reg [15:0] fault_flags_next;
   reg [1:0] irq_stat_next;
   reg [15:0] rdata_next;
   wire [FAULTS-1:0] fault_sync;
   wire [FAULTS-1:0] fault_rise;
   wire [7:0] device_identification;
   wire wr_fault;
   wire wr_stat;

   bier_sync #(.WIDTH(FAULTS)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(fault_event_in),
      .sync_out(fault_sync)
   );

   // Edge detection keeps a persistent fault from re-setting a flag right after software clears it.
   assign fault_rise = fault_sync & ~fault_seen_reg & fault_enable_reg[FAULTS-1:0];
   assign wr_fault = reg_wr && (reg_addr == `BIER_OFS_FAULT);
   assign wr_stat = reg_wr && (reg_addr == `BIER_OFS_IRQ_STAT);
   assign device_identification = {4'h0, DIE_REVISION, VARIANT};

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      fault_flags_next = fault_flags_reg;
      if (wr_fault) begin
         fault_flags_next = fault_flags_reg & ~reg_wdata;
      end
      // A new event beats a clear in the same cycle.
      fault_flags_next[FAULTS-1:0] = fault_flags_next[FAULTS-1:0] | fault_rise;
      fault_flags_next = fault_flags_next & `BIER_FAULT_LIVE;
      irq_stat_next = irq_stat_reg;
      if (wr_stat) begin
         irq_stat_next = irq_stat_reg & ~reg_wdata[1:0];
      end
      if (|fault_rise) begin
         irq_stat_next[`BIER_IRQ_FAULT_BIT] = 1'b1;
      end
   end

   always @* begin
      rdata_next = 16'h0000;
      case (reg_addr)
         `BIER_OFS_BIAS: rdata_next = pin_bias_enable_map_reg;
         `BIER_OFS_IDENT: rdata_next = {8'h00, device_identification};
         `BIER_OFS_FAULT: rdata_next = fault_flags_reg;
         `BIER_OFS_FAULT_EN: rdata_next = fault_enable_reg;
         `BIER_OFS_IRQ_STAT: rdata_next = {14'h0000, irq_stat_reg};
         `BIER_OFS_IRQ_MASK: rdata_next = {14'h0000, irq_mask_reg};
         default: rdata_next = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (rst) begin
         pin_bias_enable_map_reg <= `BIER_RST_BIAS;
         fault_flags_reg <= `BIER_RST_FAULT;
         fault_enable_reg <= `BIER_RST_FAULT_EN;
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         fault_seen_reg <= {FAULTS{1'b0}};
         reg_rdata <= 16'h0000;
         input_bias_voltage_en <= {PINS{1'b0}};
         irq <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == `BIER_OFS_BIAS)) begin
            pin_bias_enable_map_reg <= reg_wdata[PINS-1:0];
         end
         if (reg_wr && (reg_addr == `BIER_OFS_FAULT_EN)) begin
            fault_enable_reg <= reg_wdata & `BIER_FAULT_LIVE;
         end
         if (reg_wr && (reg_addr == `BIER_OFS_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata[1:0] & `BIER_IRQ_BITS;
         end
         fault_flags_reg <= fault_flags_next;
         irq_stat_reg <= irq_stat_next;
         fault_seen_reg <= fault_sync;
         if (reg_rd) begin
            reg_rdata <= rdata_next;
         end else begin
            reg_rdata <= 16'h0000;
         end
         // Bias outputs follow the map one cycle later, from a flop.
         input_bias_voltage_en <= pin_bias_enable_map_reg;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end
endmodule // bier_regs

// ===== testbench/bier_regs_assertions.sv
`timescale 1ns/1ns
module bier_chk #(
   parameter [1:0] DIE_REVISION = 2'h2,
   parameter [1:0] VARIANT = 2'h3
) (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire [15:0] input_bias_voltage_en,
   input wire irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire bw = reg_wr && reg_addr == 4'h4;
   sequence s_bset; bw ##1 !bw; endsequence
   sequence s_rd(a); reg_rd && reg_addr == a; endsequence
   // The flag may be set again by a fresh event; events are not looked at, any all-ones clear of 0x06 followed by a read is judged.
   sequence s_fclr; reg_wr && reg_addr == 4'h6 && reg_wdata == 16'hFFFF ##[1:2] s_rd(4'h6); endsequence
   bias_wr_a: assert property (s_bset |=> input_bias_voltage_en == $past(reg_wdata, 2)) else $error("bias lag");
   bias_hold_a: assert property (!bw |=> ##1 $stable(input_bias_voltage_en)) else $error("bias moved");
   bias_read_a: assert property (s_rd(4'h4) |=> reg_rdata == input_bias_voltage_en) else $error("bias read");
   ident_read_a: assert property (s_rd(4'h5) |=> reg_rdata == {12'h000, DIE_REVISION, VARIANT}) else $error("ident");
   fault_rsvd_a: assert property (s_rd(4'h6) |=> reg_rdata[15:12] == 4'h0) else $error("fault top");
   fault_clear_a: assert property (s_fclr |=> reg_rdata == 16'h0000) else $error("fault clear");
   unmapped_read_a: assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000) else $error("unmapped");
   reset_zero_a: assert property (disable iff (1'b0) rst |=> input_bias_voltage_en == 16'h0000) else $error("reset");
endmodule // bier_chk
bind bier_regs bier_chk #(.DIE_REVISION(DIE_REVISION), .VARIANT(VARIANT)) i_chk (.ref_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .input_bias_voltage_en, .irq);

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic ref_clk, rst, reg_wr, reg_rd, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, input_bias_voltage_en;
   logic [11:0] fault_event_in;
   int failures, comparisons;
   // Expected identity with the default parameters; the value is arbitrary.
   localparam logic [15:0] ident_exp = 16'h000B;
   // The enable, status and mask rows reach every decoded offset; status has no event yet, so it stays zero.
   logic [35:0] rows [8] = '{{4'h4, 16'hA5C3, 16'hA5C3}, {4'h4, 16'h5A3C, 16'h5A3C}, {4'h5, 16'hFFFF, ident_exp},
      {4'h6, 16'hFFFF, 16'h0000}, {4'hA, 16'h1234, 16'h0000}, {4'h7, 16'hFFFF, 16'h0FFF},
      {4'h9, 16'hFFFF, 16'h0003}, {4'h8, 16'hFFFF, 16'h0000}};
   bier_regs i_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_event_in,
      .input_bias_voltage_en, .irq);
   initial begin
      ref_clk = 0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
   endtask
   task end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, fault_event_in} = {3'h4, 32'h0};
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      foreach (rows[i]) begin
         wr(rows[i][35:32], rows[i][31:16]);
         rd(rows[i][35:32], rows[i][15:0]);
      end
      chk(input_bias_voltage_en, 16'h5A3C);
      $display("table test done");
      wr(4'h7, 16'h0001);
      wr(4'h9, 16'h0001);
      fault_event_in <= 12'h003;
      repeat (5) @(posedge ref_clk);
      rd(4'h6, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      wr(4'h6, 16'h0000);
      rd(4'h6, 16'h0001);
      fault_event_in <= 12'h000;
      wr(4'h6, 16'h0001);
      wr(4'h9, 16'h0000);
      rd(4'h6, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(4'h8, 16'h0001);
      wr(4'h9, 16'h0001);
      rd(4'h8, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      $display("fault test done");
      @(posedge ref_clk);
      rst <= 1;
      @(posedge ref_clk);
      rst <= 0;
      rd(4'h4, 16'h0000);
      chk(input_bias_voltage_en, 16'h0000);
      $display("reset test done");
      end_sim;
   end
   // About four times the length of the sequence above.
   initial begin
      #30000 failures++;
      end_sim;
   end
endmodule // tb_top
